// >>> design/supply_pin_cfg_pkg.sv
// Constants and carrier types for the supply monitor and pin configuration registers
package supply_pin_cfg_pkg;
    localparam logic [5:0] MONITOR_OFFSET = 6'h1B;
    localparam logic [5:0] PINCFG_OFFSET = 6'h1C;
    // Monitor register fields
    localparam int ABOVE_TRIP_BIT = 6;
    localparam int WATCH_ENABLE_BIT = 5;
    localparam int TRIP_CODE_MSB = 4;
    localparam logic WATCH_ENABLE_RESET = 1'b0;
    localparam logic [4:0] TRIP_CODE_RESET = 5'h00;
    localparam logic ABOVE_TRIP_RESET = 1'b1;
    // Pin configuration fields
    localparam int BEACON_BIT = 11;
    localparam int BYTES_INV_BIT = 10;
    localparam int THR_INV_BIT = 9;
    localparam int DELIM_INV_BIT = 8;
    localparam int CLEAR_INV_BIT = 7;
    localparam int THR_MSB = 6;
    localparam logic [6:0] THR_RESET = 7'h40;
    // Comparator settling time
    localparam int SETTLE_TIME_NS = 5000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic rx_bytes;
        logic rx_threshold;
        logic frame_delimiter;
        logic channel_clear;
    } pin_set_type;

    typedef struct packed {
        logic accept_any_beacon;
        logic rx_bytes_pin_invert;
        logic rx_threshold_pin_invert;
        logic frame_delimiter_pin_invert;
        logic channel_clear_pin_invert;
        logic [6:0] rx_threshold_bytes;
    } pin_cfg_type;
endpackage

// >>> design/supply_pin_cfg_regs.sv
// Supply monitor control and pin polarity / threshold configuration registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Software writes zero to monitor bits 15:7 and pin config bits 15:12.
// R2: Comparator result trusted only 5 us after enable and trip level programmed.
// R3: Monitor bit 6 is read-only: 1 supply above trip, 0 below.
// R4: Monitor bit 5 enables the supply monitor; resets to 0.
// R5: Monitor bits 4:0 hold trip-level code, reset 0, trip 1.25*(72-code)/27 V.
// R6: Bit 11 accepts all beacons when filtering on; ignored when filtering off.
// R7: Software sets accept-all when stored network id is 0xFFFF, else clears.
// R8: Bit 10 sets receive-bytes output polarity, 1 active low; resets 0.
// R9: Bit 9 sets receive-threshold output polarity, 1 active low; resets 0.
// R10: Bit 8 sets frame-delimiter pin polarity, 1 active low; resets 0.
// R11: Bit 7 sets channel-clear pin polarity, 1 active low; resets 0.
// R12: Bits 6:0 give queue byte count activating receive threshold; reset 64.
// R13: Polarity inverts internal active-high signal at pin, effective next cycle.
module supply_pin_cfg_regs
    import supply_pin_cfg_pkg::*;
#(
    parameter int COUNT_WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port from the configuration serial decoder
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Supply monitor
    input wire logic supply_above_trip,
    output logic supply_watch_enable,
    output logic [4:0] trip_level_code,
    output logic supply_good_flag,
    // Address filtering
    input wire logic address_filter_enable,
    output logic accept_any_beacon,
    // Status pins
    input wire pin_set_type pin_raw,
    input wire logic [COUNT_WIDTH-1:0] receive_queue_count,
    output pin_set_type pin_out
);
    if (COUNT_WIDTH < 7) begin : g_width_check
        $error("COUNT_WIDTH must hold a 7-bit threshold");
    end

    pin_cfg_type cfg;
    logic [2:0] above_sync;
    logic above_trip;
    logic [7:0] settle_count;
    logic threshold_hit;
    pin_set_type next_pins;

    wire logic wr_monitor = reg_wr && reg_addr == MONITOR_OFFSET;
    wire logic wr_pincfg = reg_wr && reg_addr == PINCFG_OFFSET;

    // Reserved bits are dropped on write and read back as zero [R1]
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_watch_enable <= WATCH_ENABLE_RESET;
            trip_level_code <= TRIP_CODE_RESET;
        end else if (wr_monitor) begin
            supply_watch_enable <= reg_wdata[WATCH_ENABLE_BIT]; // [R4]
            trip_level_code <= reg_wdata[TRIP_CODE_MSB:0]; // [R5]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, THR_RESET}; // [R12]
        end else if (wr_pincfg) begin
            cfg.accept_any_beacon <= reg_wdata[BEACON_BIT];
            cfg.rx_bytes_pin_invert <= reg_wdata[BYTES_INV_BIT]; // [R8]
            cfg.rx_threshold_pin_invert <= reg_wdata[THR_INV_BIT]; // [R9]
            cfg.frame_delimiter_pin_invert <= reg_wdata[DELIM_INV_BIT]; // [R10]
            cfg.channel_clear_pin_invert <= reg_wdata[CLEAR_INV_BIT]; // [R11]
            cfg.rx_threshold_bytes <= reg_wdata[THR_MSB:0]; // [R12]
        end
    end

    // Analog comparator is asynchronous; a change counts once stages 2 and 3 agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            above_sync <= {3{ABOVE_TRIP_RESET}};
            above_trip <= ABOVE_TRIP_RESET;
        end else begin
            above_sync <= {above_sync[1:0], supply_above_trip};
            if (above_sync[1] == above_sync[2]) begin
                above_trip <= above_sync[2]; // [R3]
            end
        end
    end

    // Settling timer restarts on any monitor write, since the trip level may have moved
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_count <= 8'h00;
            supply_good_flag <= 1'b0;
        end else if (wr_monitor || !supply_watch_enable) begin
            settle_count <= 8'h00;
            supply_good_flag <= 1'b0;
        end else if (settle_count != 8'(SETTLE_CYCLES)) begin
            settle_count <= settle_count + 8'h01;
            supply_good_flag <= settle_count == 8'(SETTLE_CYCLES - 1); // [R2]
        end
    end

    // Beacon policy only matters while address filtering is on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accept_any_beacon <= 1'b0;
        end else begin
            accept_any_beacon <= address_filter_enable && cfg.accept_any_beacon; // [R6]
        end
    end

    assign threshold_hit = receive_queue_count >= COUNT_WIDTH'(cfg.rx_threshold_bytes);

    always_comb begin
        next_pins.rx_bytes = pin_raw.rx_bytes ^ cfg.rx_bytes_pin_invert; // [R8] [R13]
        next_pins.rx_threshold = threshold_hit ^ cfg.rx_threshold_pin_invert; // [R9] [R12]
        next_pins.frame_delimiter = pin_raw.frame_delimiter ^ cfg.frame_delimiter_pin_invert; // [R10]
        next_pins.channel_clear = pin_raw.channel_clear ^ cfg.channel_clear_pin_invert; // [R11]
    end

    // Pins come out of a flop, so a polarity change shows one cycle after the write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= '0;
        end else begin
            pin_out <= next_pins; // [R13]
        end
    end

    // Read data is registered; unmapped offsets read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                MONITOR_OFFSET: reg_rdata <= {9'h000, above_trip, supply_watch_enable, trip_level_code}; // [R3]
                PINCFG_OFFSET: reg_rdata <= {4'h0, cfg.accept_any_beacon, cfg.rx_bytes_pin_invert,
                    cfg.rx_threshold_pin_invert, cfg.frame_delimiter_pin_invert,
                    cfg.channel_clear_pin_invert, cfg.rx_threshold_bytes};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    property p_good_needs_settle;
        @(posedge clk) disable iff (!reset_n)
        $rose(supply_good_flag) |-> $past(supply_watch_enable, 200) && settle_count == 8'(SETTLE_CYCLES);
    endproperty
    a_good_needs_settle: assert property (p_good_needs_settle) else $error("good flag before settling"); // [R2]

    // Assertion helper: cycles since the last monitor write with the monitor held on, saturating
    logic [7:0] watch_age;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watch_age <= 8'h00;
        end else if (wr_monitor || !supply_watch_enable) begin
            watch_age <= 8'h00;
        end else if (watch_age != 8'hFF) begin
            watch_age <= watch_age + 8'h01;
        end
    end

    property p_good_on_time;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |-> supply_good_flag == (watch_age >= 8'(SETTLE_CYCLES));
    endproperty
    a_good_on_time: assert property (p_good_on_time) else $error("good flag late"); // [R2]

    property p_read_above;
        @(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == MONITOR_OFFSET |=> reg_rdata[ABOVE_TRIP_BIT] == $past(above_trip)
            && reg_rdata[15:7] == 9'h000;
    endproperty
    a_read_above: assert property (p_read_above) else $error("monitor readback wrong"); // [R3]

    property p_enable_write;
        @(posedge clk) disable iff (!reset_n)
        wr_monitor |=> supply_watch_enable == $past(reg_wdata[WATCH_ENABLE_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not stored"); // [R4]

    property p_code_stable;
        @(posedge clk) disable iff (!reset_n)
        !wr_monitor |=> $stable(trip_level_code) && $stable(supply_watch_enable);
    endproperty
    a_code_stable: assert property (p_code_stable) else $error("monitor field changed unwritten"); // [R5]

    property p_beacon_off;
        @(posedge clk) disable iff (!reset_n)
        !address_filter_enable |=> !accept_any_beacon;
    endproperty
    a_beacon_off: assert property (p_beacon_off) else $error("beacon accept while unfiltered"); // [R6]

    property p_bytes_pin;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> pin_out.rx_bytes == ($past(pin_raw.rx_bytes) ^ $past(cfg.rx_bytes_pin_invert));
    endproperty
    a_bytes_pin: assert property (p_bytes_pin) else $error("bytes pin polarity wrong"); // [R8]

    property p_thr_pin;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> pin_out.rx_threshold == ((receive_queue_count >= COUNT_WIDTH'(cfg.rx_threshold_bytes)) ^
            cfg.rx_threshold_pin_invert) || $changed(cfg) || $changed(receive_queue_count);
    endproperty
    a_thr_pin: assert property (p_thr_pin) else $error("threshold pin wrong"); // [R9]

    property p_delim_pin;
        @(posedge clk) disable iff (!reset_n)
        wr_pincfg ##1 $stable(pin_raw.frame_delimiter) |=>
            pin_out.frame_delimiter == ($past(pin_raw.frame_delimiter) ^ $past(reg_wdata[DELIM_INV_BIT], 2));
    endproperty
    a_delim_pin: assert property (p_delim_pin) else $error("delimiter polarity late"); // [R10]

    property p_clear_pin;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> pin_out.channel_clear == ($past(pin_raw.channel_clear) ^ $past(cfg.channel_clear_pin_invert));
    endproperty
    a_clear_pin: assert property (p_clear_pin) else $error("clear pin polarity wrong"); // [R11]

    property p_thr_write;
        @(posedge clk) disable iff (!reset_n)
        wr_pincfg |=> cfg.rx_threshold_bytes == $past(reg_wdata[THR_MSB:0]);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold not stored"); // [R12]

    property p_invert_next;
        @(posedge clk) disable iff (!reset_n)
        $changed(cfg.rx_bytes_pin_invert) && $stable(pin_raw.rx_bytes) |=> $changed(pin_out.rx_bytes);
    endproperty
    a_invert_next: assert property (p_invert_next) else $error("polarity change not next cycle"); // [R13]

    c_settled: cover property (@(posedge clk) disable iff (!reset_n) $rose(supply_good_flag));
    c_beacon: cover property (@(posedge clk) disable iff (!reset_n) accept_any_beacon);
    c_thr_low: cover property (@(posedge clk) disable iff (!reset_n) cfg.rx_threshold_pin_invert && pin_out.rx_threshold);
endmodule
`default_nettype wire

// >>> verif/host_model.sv
// Host controller model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module host_model
    import supply_pin_cfg_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 6'h3F;
        reg_wr = 1'b0;
        reg_wdata = 16'hFFFF;
        reg_rd = 1'b0;
    end
    // Idle bus shows inverted values so stale data is never mistaken for valid
    task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d & ((a == MONITOR_OFFSET) ? 16'h007F : 16'h0FFF);
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic reg_read(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask
    // Accept-all only when the stored network id is the broadcast value
    task automatic pin_setup(input logic [15:0] net_id, input logic [15:0] cfg);
        reg_write(PINCFG_OFFSET, {4'h0, net_id == 16'hFFFF, cfg[10:0]});
    endtask
    task automatic settle();
        repeat (SETTLE_CYCLES + 4) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the supply monitor and pin configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb;
    import supply_pin_cfg_pkg::*;
    typedef struct packed {
        logic [15:0] nid;
        logic [15:0] cfg;
        logic [3:0] raw;
        logic [7:0] cnt;
        logic filt;
        logic [3:0] pin;
        logic acc;
    } row_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] reg_addr;
    logic reg_wr, reg_rd, supply_above_trip, supply_watch_enable, supply_good_flag;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [4:0] trip_level_code;
    logic address_filter_enable, accept_any_beacon;
    pin_set_type pin_raw, pin_out;
    logic [7:0] receive_queue_count;
    int n_errors = 0;
    int n_compared = 0;
    row_type rows [7] = '{
        '{16'h1234, 16'h0040, 4'hB, 8'h40, 1'b1, 4'hF, 1'b0},
        '{16'hFFFF, 16'h0840, 4'h0, 8'h3F, 1'b1, 4'h0, 1'b1},
        '{16'hFFFF, 16'h0840, 4'h0, 8'h3F, 1'b0, 4'h0, 1'b0},
        '{16'h1234, 16'h0780, 4'h0, 8'h00, 1'b1, 4'hB, 1'b0},
        '{16'h1234, 16'h047F, 4'hB, 8'h7E, 1'b1, 4'h3, 1'b0},
        '{16'h1234, 16'h0100, 4'h2, 8'h00, 1'b0, 4'h4, 1'b0},
        '{16'h1234, 16'h0080, 4'h1, 8'h00, 1'b0, 4'h4, 1'b0}};

    always #12.5 clk = ~clk;

    supply_pin_cfg_regs i_supply_pin_cfg_regs (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .supply_above_trip(supply_above_trip), .supply_watch_enable(supply_watch_enable),
        .trip_level_code(trip_level_code), .supply_good_flag(supply_good_flag),
        .address_filter_enable(address_filter_enable), .accept_any_beacon(accept_any_beacon),
        .pin_raw(pin_raw), .receive_queue_count(receive_queue_count), .pin_out(pin_out));
    host_model i_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        supply_above_trip = 1'b1;
        address_filter_enable = 1'b0;
        pin_raw = 4'h0;
        receive_queue_count = 8'h00;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        i_host_model.reg_read(MONITOR_OFFSET, rd);
        check(rd, 16'h0040);
        i_host_model.reg_read(PINCFG_OFFSET, rd);
        check(rd, 16'h0040);
        check({12'h0, pin_out}, 16'h0000);
        // Monitor: bit 6 written high must be ignored, comparator drives it
        supply_above_trip = 1'b0;
        i_host_model.reg_write(MONITOR_OFFSET, 16'h0065);
        repeat (100) @(negedge clk);
        check({15'h0, supply_good_flag}, 16'h0000);
        i_host_model.settle();
        check({15'h0, supply_good_flag}, 16'h0001);
        check({10'h0, supply_watch_enable, trip_level_code}, 16'h0025);
        i_host_model.reg_read(MONITOR_OFFSET, rd);
        check(rd, 16'h0025);
        supply_above_trip = 1'b1;
        repeat (8) @(negedge clk);
        i_host_model.reg_read(MONITOR_OFFSET, rd);
        check(rd, 16'h0065);
        i_host_model.reg_write(MONITOR_OFFSET, 16'h0000);
        repeat (3) @(negedge clk);
        check({14'h0, supply_good_flag, supply_watch_enable}, 16'h0000);
        // Pin polarity, threshold and beacon rows
        foreach (rows[i]) begin
            pin_raw = rows[i].raw;
            receive_queue_count = rows[i].cnt;
            address_filter_enable = rows[i].filt;
            i_host_model.pin_setup(rows[i].nid, rows[i].cfg);
            repeat (3) @(negedge clk);
            check({12'h0, pin_out}, {12'h0, rows[i].pin});
            check({15'h0, accept_any_beacon}, {15'h0, rows[i].acc});
            i_host_model.reg_read(PINCFG_OFFSET, rd);
            check(rd, rows[i].cfg);
        end
        // Polarity change shows on the pin exactly one cycle after the write edge
        i_host_model.pin_setup(16'h1234, 16'h0000);
        check({12'h0, pin_out}, 16'h0004);
        @(negedge clk);
        check({12'h0, pin_out}, 16'h0005);
        // Second reset in mid-run restores defaults
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        check({11'h0, accept_any_beacon, pin_out}, 16'h0000);
        reset_n = 1'b1;
        i_host_model.reg_read(PINCFG_OFFSET, rd);
        check(rd, 16'h0040);
        close_out();
    end
endmodule
`default_nettype wire
